// ==== shared/twmt_consts.svh ====
// constants for the two-wire master transmit sequencer
`ifndef TWMT_CONSTS_SVH
`define TWMT_CONSTS_SVH
`define TWMT_CTRL_OFF 8'h00
`define TWMT_STAT_OFF 8'h04
`define TWMT_DATA_OFF 8'h08
`define TWMT_B_FLAG 7
`define TWMT_B_ACKEN 6
`define TWMT_B_STA 5
`define TWMT_B_STO 4
`define TWMT_B_WCOL 3
`define TWMT_B_EN 2
`define TWMT_B_IE 0
`define TWMT_ST_START 8'h08
`define TWMT_ST_REP 8'h10
`define TWMT_ST_AW_ACK 8'h18
`define TWMT_ST_AW_NACK 8'h20
`define TWMT_ST_D_ACK 8'h28
`define TWMT_ST_D_NACK 8'h30
`define TWMT_ST_ARB 8'h38
`define TWMT_ST_AR_ACK 8'h40
`define TWMT_ST_AR_NACK 8'h48
`define TWMT_ST_RD_ACK 8'h50
`define TWMT_ST_RD_NACK 8'h58
`define TWMT_ST_IDLE 8'hf8
`define TWMT_CLK_NS 8
`define TWMT_QUARTER_NS 2500
`define TWMT_QUARTER_CYC (`TWMT_QUARTER_NS / `TWMT_CLK_NS)
`endif

// ==== shared/twmt_pkg.sv ====
// types for the two-wire master transmit sequencer
package twmt_pkg;
  typedef enum logic [2:0] {M_IDLE, M_WAIT_FREE, M_START, M_HOLD, M_BYTE, M_STOP} twmt_mst_t;
  typedef enum logic [1:0] {E_IDLE, E_START, E_BIT, E_STOP} twmt_est_t;
  typedef enum logic [1:0] {C_START, C_BYTE, C_STOP} twmt_cmd_t;
  typedef enum logic [1:0] {S_CTRL, S_STAT, S_DATA, S_NONE} twmt_sel_t;
  typedef struct packed {
    twmt_est_t st;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [15:0] tmr;
    logic [7:0] sh;
    logic rx;
    logic ack_out;
    logic scl_low;
    logic sda_low;
    logic ack_in;
    logic arb;
    logic done;
  } twmt_eng_t;
  typedef struct packed {
    twmt_mst_t st;
    logic flag;
    logic ack_en;
    logic sta;
    logic sto;
    logic wc;
    logic en;
    logic ie;
    logic [1:0] presc;
    logic [7:0] status;
    logic [7:0] data;
    logic owned;
    logic addr_ph;
    logic rx_mode;
    logic ph_wr;
    twmt_sel_t ph_sel;
    logic [31:0] hrdata;
    logic cmd_valid;
    twmt_cmd_t cmd;
  } twmt_main_t;
  typedef struct packed {
    logic busy;
    logic scl_q;
    logic sda_q;
  } twmt_mon_t;
endpackage : twmt_pkg

// ==== hdl/twmt_bus_monitor.sv ====
// bus free/busy tracker from start and stop conditions on the lines
`timescale 1ns/1ns
module twmt_bus_monitor
  import twmt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic busy
);
  twmt_mon_t r, s;

  // start sets busy, stop clears it
  always_comb begin
    s = r;
    s.scl_q = scl_i;
    s.sda_q = sda_i;
    if (scl_i && r.scl_q && r.sda_q && !sda_i) s.busy = 1'b1;
    else if (scl_i && r.scl_q && !r.sda_q && sda_i) s.busy = 1'b0;
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) r <= '0;
    else r <= s;
  end

  assign busy = r.busy;
endmodule : twmt_bus_monitor

// ==== hdl/twmt_bit_engine.sv ====
// bit-level engine: start, stop and nine-bit byte frames on open-drain lines
`timescale 1ns/1ns
`include "twmt_consts.svh"
module twmt_bit_engine
  import twmt_pkg::*;
#(
  parameter logic [15:0] QUARTER = 16'(`TWMT_QUARTER_CYC)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic enable,
  input wire logic cmd_valid,
  input wire twmt_cmd_t cmd,
  input wire logic [7:0] tx_byte,
  input wire logic rx_mode,
  input wire logic ack_out,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  output logic done,
  output logic ack_in,
  output logic arb_lost,
  output logic [7:0] rx_byte
);
  twmt_eng_t r, s;

  // quarter-bit sequencer; timer halts while a slave stretches the clock
  always_comb begin
    s = r;
    s.done = 1'b0;
    case (r.st)
      E_IDLE: if (cmd_valid) begin
        s.tmr = QUARTER;
        s.q = 2'd0;
        s.bitn = 4'd0;
        s.sh = tx_byte;
        s.rx = rx_mode;
        s.ack_out = ack_out;
        s.arb = 1'b0;
        case (cmd)
          C_START: begin
            s.st = E_START;
            s.sda_low = 1'b0;
          end
          C_BYTE: s.st = E_BIT;
          default: s.st = E_STOP;
        endcase
      end
      default: if (r.tmr != 16'h0000) begin
        if (r.scl_low || scl_i) s.tmr = r.tmr - 16'h0001;
      end else begin
        s.tmr = QUARTER;
        s.q = r.q + 2'd1;
        case (r.st)
          E_START: case (r.q)
            2'd0: s.scl_low = 1'b0;
            2'd1: s.sda_low = 1'b1;
            2'd2: s.scl_low = 1'b1;
            default: begin
              s.st = E_IDLE;
              s.done = 1'b1;
            end
          endcase
          E_STOP: case (r.q)
            2'd0: s.sda_low = 1'b1;
            2'd1: s.scl_low = 1'b0;
            2'd2: s.sda_low = 1'b0;
            default: begin
              s.st = E_IDLE;
              s.done = 1'b1;
            end
          endcase
          default: case (r.q)
            2'd0: s.sda_low = (r.bitn == 4'd8) ? (r.rx & r.ack_out) : (~r.rx & ~r.sh[7]);
            2'd1: s.scl_low = 1'b0;
            2'd2: if (r.bitn == 4'd8) s.ack_in = ~sda_i;
            else begin
              s.sh = {r.sh[6:0], sda_i};
              // released a one but line reads zero: another master won
              if (!r.rx && r.sh[7] && !sda_i) begin
                s.scl_low = 1'b0;
                s.sda_low = 1'b0;
                s.arb = 1'b1;
                s.done = 1'b1;
                s.st = E_IDLE;
              end
            end
            default: begin
              s.scl_low = 1'b1;
              if (r.bitn == 4'd8) begin
                s.st = E_IDLE;
                s.done = 1'b1;
              end else s.bitn = r.bitn + 4'd1;
            end
          endcase
        endcase
      end
    endcase
    if (!enable) s = '0;
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) r <= '0;
    else r <= s;
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = r.scl_low;
  assign sda_oe = r.sda_low;
  assign done = r.done;
  assign ack_in = r.ack_in;
  assign arb_lost = r.arb;
  assign rx_byte = r.sh;
endmodule : twmt_bit_engine

// ==== hdl/twmt_top.sv ====
// master transmit sequencer: AHB-Lite registers, event flag and status codes
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`include "twmt_consts.svh"
module twmt_top
  import twmt_pkg::*;
#(
  parameter logic [15:0] QUARTER = 16'(`TWMT_QUARTER_CYC)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);
  localparam twmt_main_t RST = '{st: M_IDLE, ph_sel: S_NONE, cmd: C_START,
                                 status: `TWMT_ST_IDLE, default: '0};

  twmt_main_t r, s;
  logic eng_done;
  logic eng_ack;
  logic eng_arb;
  logic [7:0] eng_rx;
  logic bus_busy;
  logic acc;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic clr;
  logic [7:0] wd;

  // register select from a byte address
  function automatic twmt_sel_t reg_sel(input logic [31:0] a);
    case (a[7:0])
      `TWMT_CTRL_OFF: reg_sel = S_CTRL;
      `TWMT_STAT_OFF: reg_sel = S_STAT;
      `TWMT_DATA_OFF: reg_sel = S_DATA;
      default: reg_sel = S_NONE;
    endcase
  endfunction : reg_sel

  // bus decode and data-phase write strobes
  assign acc = hsel & htrans[1] & hready;
  assign wd = hwdata[7:0];
  assign wr_ctrl = r.ph_wr && (r.ph_sel == S_CTRL);
  assign wr_stat = r.ph_wr && (r.ph_sel == S_STAT);
  assign wr_data = r.ph_wr && (r.ph_sel == S_DATA);
  assign clr = wr_ctrl && wd[`TWMT_B_FLAG] && r.flag;

  // next state: bus slave, register writes and the transfer sequencer
  always_comb begin
    s = r;
    s.cmd_valid = 1'b0;
    s.ph_wr = acc & hwrite & (hsize == 3'b010);
    s.ph_sel = reg_sel(haddr);
    if (acc && !hwrite) begin
      case (reg_sel(haddr))
        S_CTRL: s.hrdata = {24'h000000, r.flag, r.ack_en, r.sta, r.sto,
                            r.wc, r.en, 1'b0, r.ie};
        S_STAT: s.hrdata = {24'h000000, r.status[7:3], 1'b0, r.presc};
        S_DATA: s.hrdata = {24'h000000, r.data};
        default: s.hrdata = 32'h00000000;
      endcase
    end
    // control fields; the flag clears only by writing a one
    if (wr_ctrl) begin
      s.ack_en = wd[`TWMT_B_ACKEN];
      s.sta = wd[`TWMT_B_STA];
      s.sto = wd[`TWMT_B_STO];
      s.en = wd[`TWMT_B_EN];
      s.ie = wd[`TWMT_B_IE];
    end
    if (wr_stat) s.presc = wd[1:0];
    // data writes load only while the flag is up
    if (wr_data) begin
      if (r.flag) begin
        s.data = wd;
        s.wc = 1'b0;
      end else s.wc = 1'b1;
    end
    if (clr) s.flag = 1'b0;
    case (r.st)
      M_IDLE: begin
        s.owned = 1'b0;
        if (wr_ctrl && wd[`TWMT_B_STA] && wd[`TWMT_B_EN]) s.st = M_WAIT_FREE;
      end
      M_WAIT_FREE: if (!bus_busy) begin
        s.cmd_valid = 1'b1;
        s.cmd = C_START;
        s.st = M_START;
      end
      M_START: if (eng_done) begin
        s.status = r.owned ? `TWMT_ST_REP : `TWMT_ST_START;
        s.owned = 1'b1;
        s.addr_ph = 1'b1;
        s.rx_mode = 1'b0;
        s.flag = 1'b1;
        s.st = M_HOLD;
      end
      // suspended until software clears the flag
      M_HOLD: if (clr) begin
        if (r.status == `TWMT_ST_ARB) begin
          s.owned = 1'b0;
          s.st = wd[`TWMT_B_STA] ? M_WAIT_FREE : M_IDLE;
        end else if (wd[`TWMT_B_STO]) begin
          s.cmd_valid = 1'b1;
          s.cmd = C_STOP;
          s.st = M_STOP;
        end else if (wd[`TWMT_B_STA]) begin
          s.cmd_valid = 1'b1;
          s.cmd = C_START;
          s.st = M_START;
        end else begin
          s.cmd_valid = 1'b1;
          s.cmd = C_BYTE;
          s.st = M_BYTE;
        end
      end
      M_BYTE: if (eng_done) begin
        s.flag = 1'b1;
        s.st = M_HOLD;
        if (eng_arb) begin
          s.status = `TWMT_ST_ARB;
          s.owned = 1'b0;
        end else if (r.addr_ph) begin
          s.addr_ph = 1'b0;
          s.rx_mode = r.data[0];
          if (r.data[0]) s.status = eng_ack ? `TWMT_ST_AR_ACK : `TWMT_ST_AR_NACK;
          else s.status = eng_ack ? `TWMT_ST_AW_ACK : `TWMT_ST_AW_NACK;
        end else if (r.rx_mode) begin
          s.data = eng_rx;
          s.status = r.ack_en ? `TWMT_ST_RD_ACK : `TWMT_ST_RD_NACK;
        end else begin
          s.status = eng_ack ? `TWMT_ST_D_ACK : `TWMT_ST_D_NACK;
        end
      end
      M_STOP: if (eng_done) begin
        s.sto = 1'b0;
        s.owned = 1'b0;
        s.status = `TWMT_ST_IDLE;
        s.st = r.sta ? M_WAIT_FREE : M_IDLE;
      end
      default: s.st = M_IDLE;
    endcase
    // disabling the interface returns the sequencer to idle, drops ownership and any pending command, and releases the lines
    if (!s.en) begin
      s.st = M_IDLE;
      s.owned = 1'b0;
      s.cmd_valid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) r <= RST;
    else r <= s;
  end

  // line engine; rx only for data bytes after a read address
  twmt_bit_engine #(
    .QUARTER(QUARTER)
  ) u_engine (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(r.en),
    .cmd_valid(r.cmd_valid),
    .cmd(r.cmd),
    .tx_byte(r.data),
    .rx_mode(r.rx_mode & ~r.addr_ph),
    .ack_out(r.ack_en),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_o(scl_o),
    .scl_oe(scl_oe),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .done(eng_done),
    .ack_in(eng_ack),
    .arb_lost(eng_arb),
    .rx_byte(eng_rx)
  );

  // free/busy view of the shared bus
  twmt_bus_monitor u_monitor (
    .hclk(hclk),
    .hresetn(hresetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .busy(bus_busy)
  );

  // bus answers and interrupt request
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.hrdata;
  assign irq = r.flag & r.ie;

  // checks on sequencer behaviour
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence seq_hold_clear;
    r.st == M_HOLD && clr && r.status != `TWMT_ST_ARB && wd[`TWMT_B_EN];
  endsequence

  sequence seq_stop_done;
    r.st == M_STOP && eng_done;
  endsequence

  sequence seq_arb_clear;
    r.st == M_HOLD && clr && r.status == `TWMT_ST_ARB && wd[`TWMT_B_EN];
  endsequence

  AST_REP_STATUS: assert property (r.st == M_START && eng_done && r.owned |=>
    r.status == 8'h10 && r.flag && r.addr_ph)
    else $error("repeated start not reported as 0x10");

  AST_ADDR_SEND: assert property (seq_hold_clear ##0 (!wd[`TWMT_B_STA] &&
    !wd[`TWMT_B_STO]) |=> r.cmd_valid && r.cmd == C_BYTE ##1 r.st == M_BYTE)
    else $error("flag clear did not send the loaded byte");

  AST_ADDR_STATUS: assert property (r.st == M_BYTE && eng_done && !eng_arb &&
    r.addr_ph && !r.data[0] |=> r.status == ($past(eng_ack) ? 8'h18 : 8'h20))
    else $error("wrong status after write address");

  AST_DATA_STATUS: assert property (r.st == M_BYTE && eng_done && !eng_arb &&
    !r.addr_ph && !r.rx_mode |=> r.status == ($past(eng_ack) ? 8'h28 : 8'h30) && r.flag)
    else $error("wrong status after data byte");

  AST_RESTART_SEND: assert property (seq_hold_clear ##0 (wd[`TWMT_B_STA] &&
    !wd[`TWMT_B_STO]) |=> r.cmd_valid && r.cmd == C_START)
    else $error("start-only clear did not issue a start");

  AST_STOP_CLEARS: assert property (seq_stop_done |=> !r.sto && !r.owned &&
    r.status == 8'hf8)
    else $error("stop request not cleared after stop");

  AST_STOP_THEN_START: assert property (seq_stop_done ##0 r.sta && r.en |=>
    r.st == M_WAIT_FREE)
    else $error("stop with start pending did not go on to start");

  AST_ARB_STATUS: assert property (r.st == M_BYTE && eng_done && eng_arb |=>
    r.status == 8'h38 && r.flag && !scl_oe && !sda_oe)
    else $error("arbitration loss not reported or lines held");

  AST_ARB_RELEASE: assert property (seq_arb_clear ##0 !wd[`TWMT_B_STA] |=>
    r.st == M_IDLE ##1 !scl_oe && !sda_oe)
    else $error("bus not released after arbitration loss");

  AST_ARB_RETRY: assert property (seq_arb_clear ##0 wd[`TWMT_B_STA] |=>
    r.st == M_WAIT_FREE)
    else $error("no new start after arbitration loss");

  AST_SUSPEND: assert property (r.flag && r.en |-> r.st == M_HOLD &&
    !r.cmd_valid)
    else $error("bus activity while flag is set");

  AST_WCOL: assert property (wr_data && !r.flag && r.st != M_BYTE |=> r.wc &&
    r.data == $past(r.data))
    else $error("data write with flag low not discarded");

  AST_IRQ: assert property ($rose(r.flag) && r.ie |-> irq ##1 (irq || !r.flag))
    else $error("interrupt request not following flag");

endmodule : twmt_top

// ==== verif/twmt_slave_model.sv ====
// behavioural slave receiver on the open-drain lines, with stretch and arbitration hold
`timescale 1ns/1ns
module twmt_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_on,
  input wire logic stretch,
  input wire logic hold_low,
  output logic scl_pull,
  output logic sda_pull,
  output logic [7:0] last_byte,
  output logic [7:0] starts,
  output logic [7:0] stops
);
  logic [3:0] cnt;
  logic [7:0] sh;
  logic ack_drv;
  logic ps;
  logic pd;
  initial begin
    cnt = 4'h0;
    sh = 8'h00;
    ack_drv = 1'b0;
    last_byte = 8'h00;
    starts = 8'h00;
    stops = 8'h00;
    ps = 1'b1;
    pd = 1'b1;
  end
  // hold_low keeps data low so the master loses arbitration when it sends a one
  assign sda_pull = ack_drv | hold_low;
  // frame decoder: conditions while clock high, bits on clock edges
  always @(scl or sda) begin
    if (scl === 1'b1 && ps === 1'b1 && sda !== pd) begin
      if (sda === 1'b0) starts = starts + 8'h01;
      else stops = stops + 8'h01;
      cnt = 4'h0;
      ack_drv = 1'b0;
    end else if (scl === 1'b1 && ps === 1'b0) begin
      if (cnt < 4'h8) sh = {sh[6:0], sda};
      cnt = cnt + 4'h1;
    end else if (scl === 1'b0 && ps === 1'b1) begin
      if (cnt == 4'h8) last_byte = sh;
      ack_drv = (cnt == 4'h8) && ack_on;
      if (cnt == 4'h9) cnt = 4'h0;
    end
    ps = scl;
    pd = sda;
  end
  // optional clock stretch during the acknowledge bit
  initial scl_pull = 1'b0;
  always @(posedge ack_drv) begin
    if (stretch) begin
      scl_pull = 1'b1;
      #200 scl_pull = 1'b0;
    end
  end
endmodule : twmt_slave_model

// ==== verif/test_twmt_top.sv ====
// self-checking bench for the two-wire master transmit sequencer
`timescale 1ns/1ns
module test_twmt_top;
  import twmt_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, ie_set, a;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic scl_o, scl_oe, sda_o, sda_oe, scl, sda, p_scl, p_sda, ack_on, stretch, hold_low;
  logic [7:0] last_byte, starts, stops, d, s0;
  int bad_count, num_checks;
  // open-drain lines with pull-ups
  assign scl = (scl_oe ? scl_o : 1'b1) & ~p_scl;
  assign sda = (sda_oe ? sda_o : 1'b1) & ~p_sda;
  twmt_top #(.QUARTER(16'h0004)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_i(scl),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  twmt_slave_model slave (.scl(scl), .sda(sda), .ack_on(ack_on), .stretch(stretch),
    .hold_low(hold_low), .scl_pull(p_scl), .sda_pull(p_sda), .last_byte(last_byte),
    .starts(starts), .stops(stops));
  // clock
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // single word transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    rd = hrdata;
  endtask : ahb
  // write control (0 = only wait), poll the event flag, compare irq and masked status
  task automatic go(input logic [7:0] c, input logic [7:0] st);
    int n;
    n = 0;
    if (c !== 8'h00) ie_set = c[0];
    if (c !== 8'h00) ahb(1'b1, 8'h00, {24'h0, c}, r);
    r = 32'h0;
    while (r[7] !== 1'b1 && n < 3000) begin
      ahb(1'b0, 8'h00, 32'h0, r);
      n++;
    end
    chk_bit("event flag", 1'b1, r[7]);
    chk_bit("irq", ie_set, irq);
    chk_val("okay and open drain", 8'h00, {5'h0, hresp, scl_o, sda_o});
    ahb(1'b0, 8'h04, 32'h0, r);
    chk_val("status", st, r[7:0] & 8'hf8);
  endtask : go
  task automatic load(input logic [7:0] v);
    ahb(1'b1, 8'h08, {24'h0, v}, r);
  endtask : load
  // watchdog
  initial begin
    repeat (100000) @(posedge hclk);
    bad_count++;
    summarize();
  end
  // main sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; ack_on = 1'b1; stretch = 1'b0; hold_low = 1'b0;
    bad_count = 0; num_checks = 0; ie_set = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    void'($urandom(17));
    @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0, r);
    chk_val("control reset", 8'h00, r[7:0]);
    ahb(1'b0, 8'h04, 32'h0, r);
    chk_val("status reset", 8'hf8, r[7:0]);
    ahb(1'b1, 8'h0c, 32'hff, r);
    ahb(1'b0, 8'h0c, 32'h0, r);
    chk_val("unmapped", 8'h00, r[7:0]);
    load(8'h5a);
    ahb(1'b0, 8'h00, 32'h0, r);
    chk_bit("collision set", 1'b1, r[3]);
    $display("test registers done");
    go(8'ha5, 8'h08);
    d = 8'($urandom_range(0, 127)) << 1;
    load(d);
    ahb(1'b0, 8'h00, 32'h0, r);
    chk_bit("collision clear", 1'b0, r[3]);
    go(8'h84, 8'h18);
    chk_val("address on wire", d, last_byte);
    s0 = {6'h0, scl_oe, sda_oe};
    repeat (40) @(posedge hclk);
    chk_val("lines held", s0, {6'h0, scl_oe, sda_oe});
    for (int i = 0; i < 6; i++) begin
      a = 1'($urandom_range(0, 1));
      ack_on <= a;
      stretch <= 1'($urandom_range(0, 1));
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom());
      load(d);
      go({7'h42, a}, a ? 8'h28 : 8'h30);
      chk_val("data on wire", d, last_byte);
    end
    $display("test write transfer done");
    s0 = stops;
    go(8'ha4, 8'h10);
    ack_on <= 1'b0;
    load(8'h3c);
    go(8'h84, 8'h20);
    load(8'h96);
    go(8'h84, 8'h30);
    go(8'ha4, 8'h10);
    load(8'h3d);
    go(8'h84, 8'h48);
    chk_val("no stop between", s0, stops);
    chk_bit("starts seen", 1'b1, starts > 8'h02);
    go(8'hb4, 8'h08);
    chk_val("stop before start", s0 + 8'h01, stops);
    ahb(1'b0, 8'h00, 32'h0, r);
    chk_bit("stop self clear", 1'b0, r[4]);
    ack_on <= 1'b1;
    load(8'h3c);
    go(8'h84, 8'h18);
    ahb(1'b1, 8'h00, 32'h94, r);
    repeat (60) @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0, r);
    chk_val("stop count", s0 + 8'h02, stops);
    chk_val("stop and flag", 8'h00, r[7:0] & 8'h90);
    $display("test restart and stop done");
    go(8'ha4, 8'h08);
    hold_low <= 1'b1;
    load(8'ha0);
    go(8'h84, 8'h38);
    chk_val("lines after loss", 8'h00, {6'h0, scl_oe, sda_oe});
    ahb(1'b1, 8'h00, 32'ha4, r);
    repeat (60) @(posedge hclk);
    chk_bit("waits for free bus", 1'b0, scl_oe);
    hold_low <= 1'b0;
    go(8'h00, 8'h08);
    load(8'h3c);
    go(8'h84, 8'h18);
    hold_low <= 1'b1;
    load(8'hf0);
    go(8'h84, 8'h38);
    ahb(1'b1, 8'h00, 32'h84, r);
    repeat (60) @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0, r);
    chk_val("released idle", 8'h00, {r[7], 5'h0, scl_oe, sda_oe});
    hold_low <= 1'b0;
    $display("test arbitration done");
    summarize();
  end
endmodule : test_twmt_top
